// file: common/cmg_map.svh
// Purpose: Register map and field positions of the comparator mask gating block.
// Assumes: One 16-bit control register held in the low half of a 32-bit Avalon word.
// Notes: Offsets are byte addresses.
`ifndef CMG_MAP_SVH
`define CMG_MAP_SVH
`define CMG_CTRL_OFFSET 4'h0
`define CMG_STATUS_OFFSET 4'h4
`define CMG_CTRL_RESET 16'h0000
`define CMG_CTRL_WMASK 16'hBFFF
`define CMG_BIT_LEVEL_SEL 15
`define CMG_BIT_OR_C_TRUE 13
`define CMG_BIT_OR_C_INV 12
`define CMG_BIT_OR_B_TRUE 11
`define CMG_BIT_OR_B_INV 10
`define CMG_BIT_OR_A_TRUE 9
`define CMG_BIT_OR_A_INV 8
`define CMG_BIT_AND_INV_TO_OR 7
`define CMG_BIT_AND_TRUE_TO_OR 6
`define CMG_BIT_AND_C_TRUE 5
`define CMG_BIT_AND_C_INV 4
`define CMG_BIT_AND_B_TRUE 3
`define CMG_BIT_AND_B_INV 2
`define CMG_BIT_AND_A_TRUE 1
`define CMG_BIT_AND_A_INV 0
`endif

// file: common/cmg_pkg.sv
// Purpose: Types shared by the comparator mask gating block.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
package cmg_pkg;
  typedef logic [15:0] cmg_ctrl_t;
  typedef enum logic [2:0] {
    CMG_IDLE = 3'h1,
    CMG_RESP = 3'h2,
    CMG_DONE = 3'h4
  } cmg_bus_e;
endpackage

// file: common/cmg_gate_if.sv
// Purpose: Carries the control word and mask signals to the gating core.
// Assumes: Single clock domain.
// Notes: Purely combinational signals.
`timescale 1ns/1ps
interface cmg_gate_if;
  cmg_pkg::cmg_ctrl_t ctrl;
  logic [2:0] mask_in;
  logic comp_in;
  logic and_res;
  logic or_res;
  logic comp_out;
  modport host (output ctrl, output mask_in, output comp_in, input and_res, input or_res, input comp_out);
  modport core (input ctrl, input mask_in, input comp_in, output and_res, output or_res, output comp_out);
endinterface

// file: src/cmg_gate_core.sv
// Purpose: AND/OR mask gating of the comparator signal.
// Assumes: Control word is stable from a register.
// Notes: Fully combinational.
`timescale 1ns/1ps
`include "cmg_map.svh"
module cmg_gate_core (
  cmg_gate_if.core gi
);
  logic [2:0] sel_true;
  logic [2:0] sel_inv;
  logic [2:0] and_terms;
  logic [2:0] or_terms;
  logic and_any;
  assign sel_true = {gi.ctrl[`CMG_BIT_AND_C_TRUE], gi.ctrl[`CMG_BIT_AND_B_TRUE], gi.ctrl[`CMG_BIT_AND_A_TRUE]};
  assign sel_inv = {gi.ctrl[`CMG_BIT_AND_C_INV], gi.ctrl[`CMG_BIT_AND_B_INV], gi.ctrl[`CMG_BIT_AND_A_INV]};
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_in
      // Unselected inputs contribute a one to the AND and a zero to the OR.
      assign and_terms[i] = (~sel_true[i] | gi.mask_in[i]) & (~sel_inv[i] | ~gi.mask_in[i]);
      assign or_terms[i] = (gi.ctrl[`CMG_BIT_OR_A_TRUE + 2 * i] & gi.mask_in[i])
        | (gi.ctrl[`CMG_BIT_OR_A_INV + 2 * i] & ~gi.mask_in[i]);
    end
  endgenerate
  // With no AND input selected the AND result is held low.
  assign and_any = |(sel_true | sel_inv);
  assign gi.and_res = and_any & (&and_terms);
  assign gi.or_res = (|or_terms) | (gi.ctrl[`CMG_BIT_AND_TRUE_TO_OR] & gi.and_res)
    | (gi.ctrl[`CMG_BIT_AND_INV_TO_OR] & ~gi.and_res);
  // A masked low event is forced high; a masked high event is forced low.
  assign gi.comp_out = gi.ctrl[`CMG_BIT_LEVEL_SEL] ? (gi.comp_in | gi.or_res)
    : (gi.comp_in & ~gi.or_res);
endmodule

// file: src/cmg_top.sv
// Purpose: Comparator mask gating block with its Avalon-MM control register.
// Assumes: One clock, synchronous active-high reset, inputs synchronous to clk.
// Notes: Gating path is combinational from inputs to comp_out.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cmg_map.svh"
module cmg_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mask_input_a,
  input wire logic mask_input_b,
  input wire logic mask_input_c,
  input wire logic comp_in,
  output logic comp_out,
  output logic and_gate_result
);
  ////////////////////////////////////////////////////////////////////////////
  cmg_pkg::cmg_ctrl_t ctrl_reg;
  cmg_pkg::cmg_ctrl_t ctrl_next;
  cmg_pkg::cmg_bus_e st_reg;
  cmg_pkg::cmg_bus_e st_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  cmg_gate_if gi ();

  // Byte-lane merge of a write into the control word.
  function automatic cmg_pkg::cmg_ctrl_t merge(input cmg_pkg::cmg_ctrl_t old, input logic [31:0] wd,
                                               input logic [3:0] be);
    cmg_pkg::cmg_ctrl_t r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r & `CMG_CTRL_WMASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // An access met in idle waits one cycle, then completes with waitrequest low.
  assign req = avs_read | avs_write;

  always_comb begin
    st_next = st_reg;
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    case (st_reg)
      cmg_pkg::CMG_IDLE: begin
        if (req) begin
          st_next = cmg_pkg::CMG_RESP;
          rdata_next = 32'h0000_0000;
          if (avs_read && avs_address == `CMG_CTRL_OFFSET) begin
            rdata_next = {16'h0000, ctrl_reg};
          end else if (avs_read && avs_address == `CMG_STATUS_OFFSET) begin
            rdata_next = {29'h0000_0000, gi.comp_out, gi.or_res, gi.and_res};
          end
        end
      end
      cmg_pkg::CMG_RESP: begin
        st_next = cmg_pkg::CMG_DONE;
        if (avs_write && avs_address == `CMG_CTRL_OFFSET) begin
          ctrl_next = merge(ctrl_reg, avs_writedata, avs_byteenable);
        end
      end
      cmg_pkg::CMG_DONE: begin
        st_next = cmg_pkg::CMG_IDLE;
      end
      default: begin
        st_next = cmg_pkg::CMG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= cmg_pkg::CMG_IDLE;
      ctrl_reg <= `CMG_CTRL_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = ~(st_reg == cmg_pkg::CMG_RESP);
  assign avs_readdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  assign gi.ctrl = ctrl_reg;
  assign gi.mask_in = {mask_input_c, mask_input_b, mask_input_a};
  assign gi.comp_in = comp_in;

  cmg_gate_core u_core (
    .gi(gi)
  );

  assign comp_out = gi.comp_out;
  assign and_gate_result = gi.and_res;

  ////////////////////////////////////////////////////////////////////////////
  chk_or_b_true: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0800 && mask_input_b) |-> gi.or_res) else $error("true B did not reach OR");
  chk_or_b_inv: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0400) |-> (gi.or_res == ~mask_input_b)) else $error("inverted B path wrong");
  chk_or_a_true: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0200) |-> (gi.or_res == mask_input_a)) else $error("true A path wrong");
  chk_or_a_inv: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0100) |-> (gi.or_res == ~mask_input_a)) else $error("inverted A path wrong");
  chk_or_c_pair: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h2000 || ctrl_reg == 16'h1000) |-> (gi.or_res == (mask_input_c ^ ctrl_reg[12])))
    else $error("C input path to OR wrong");
  chk_or_none: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[15:6] == 10'h000) |-> !gi.or_res)
    else $error("OR active with nothing routed");
  chk_or_c_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[13:12] == 2'b11) |-> gi.or_res) else $error("C true and inverted did not force OR");
  chk_or_b_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[11:10] == 2'b11) |-> gi.or_res) else $error("B true and inverted did not force OR");
  chk_or_a_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[9:8] == 2'b11) |-> gi.or_res) else $error("A true and inverted did not force OR");
  chk_and_inv_empty: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[7:0] == 8'h80) |-> gi.or_res) else $error("inverted empty AND did not reach OR");
  chk_and_inv_or: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0082) |-> (gi.or_res == ~mask_input_a)) else $error("inverted AND path wrong");
  chk_and_true_or: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0060) |-> (gi.or_res == mask_input_c)) else $error("true AND path wrong");
  chk_level_high: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[15] && gi.or_res) |-> comp_out) else $error("low event not blocked");
  chk_level_low: assert property (@(posedge clk) disable iff (srst)
    (!ctrl_reg[15] && gi.or_res) |-> !comp_out) else $error("high event not blocked");
  chk_and_sel: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[5:0] == 6'h06) |-> (gi.and_res == (mask_input_a & ~mask_input_b))) else $error("AND select wrong");
  chk_and_none: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[5:0] == 6'h00) |-> !gi.and_res) else $error("AND high with no input selected");
  chk_and_a_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[1:0] == 2'b11) |-> !gi.and_res) else $error("AND high with A true and inverted");
  chk_and_b_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[3:2] == 2'b11) |-> !gi.and_res) else $error("AND high with B true and inverted");
  chk_and_c_both: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg[5:4] == 2'b11) |-> !gi.and_res) else $error("AND high with C true and inverted");
  chk_and_only_c: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0020) |-> (gi.and_res == mask_input_c)) else $error("true C into AND wrong");
  chk_and_b_true: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0008) |-> (gi.and_res == mask_input_b)) else $error("true B into AND wrong");
  chk_and_b_inv: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0004) |-> (gi.and_res == ~mask_input_b)) else $error("inverted B into AND wrong");
  chk_and_a_inv: assert property (@(posedge clk) disable iff (srst)
    (ctrl_reg == 16'h0001) |-> (gi.and_res == ~mask_input_a)) else $error("inverted A into AND wrong");
  chk_pass_through: assert property (@(posedge clk) disable iff (srst)
    !gi.or_res |-> (comp_out == comp_in)) else $error("unmasked comparator signal altered");
  chk_write_lands: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `CMG_CTRL_OFFSET && avs_byteenable == 4'hF)
    |=> (ctrl_reg == ($past(avs_writedata[15:0]) & `CMG_CTRL_WMASK) && st_reg == cmg_pkg::CMG_DONE))
    else $error("register write lost");

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake steps: a request met in idle, the single answer cycle, then one rest cycle.
  sequence s_bus_taken;
    (st_reg == cmg_pkg::CMG_IDLE) && req;
  endsequence
  sequence s_bus_answer;
    !avs_waitrequest;
  endsequence
  sequence s_bus_rest;
    avs_waitrequest && (st_reg == cmg_pkg::CMG_DONE);
  endsequence
  chk_bus_answer: assert property (@(posedge clk) disable iff (srst)
    s_bus_taken |=> s_bus_answer ##1 s_bus_rest)
    else $error("waitrequest not low for exactly one cycle");
  chk_ctrl_readback: assert property (@(posedge clk) disable iff (srst)
    (st_reg == cmg_pkg::CMG_IDLE && avs_read && avs_address == `CMG_CTRL_OFFSET)
    |=> (avs_readdata == {16'h0000, $past(ctrl_reg)}))
    else $error("control read back wrong");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (srst)
    (st_reg == cmg_pkg::CMG_IDLE && avs_read && avs_address != `CMG_CTRL_OFFSET
      && avs_address != `CMG_STATUS_OFFSET) |=> (avs_readdata == 32'h0000_0000))
    else $error("unmapped read not zero");
  chk_unmapped_write: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address != `CMG_CTRL_OFFSET) |=> $stable(ctrl_reg))
    else $error("unmapped write changed control");
  chk_status_upper: assert property (@(posedge clk) disable iff (srst)
    (st_reg == cmg_pkg::CMG_IDLE && avs_read && avs_address == `CMG_STATUS_OFFSET)
    |=> (avs_readdata[31:3] == 29'h0000_0000)) else $error("status upper bits not zero");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (srst)
    !(st_reg == cmg_pkg::CMG_IDLE && req) |=> $stable(avs_readdata))
    else $error("read data changed without a request");
  chk_reserved_bit: assert property (@(posedge clk) disable iff (srst)
    !ctrl_reg[14]) else $error("reserved control bit set");
  chk_reset_value: assert property (@(posedge clk)
    srst |=> (ctrl_reg == `CMG_CTRL_RESET && avs_waitrequest && avs_readdata == 32'h0000_0000))
    else $error("reset state wrong");
  chk_lane_keep_high: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `CMG_CTRL_OFFSET && !avs_byteenable[1])
    |=> (ctrl_reg[15:8] == $past(ctrl_reg[15:8])))
    else $error("disabled upper lane written");
  chk_lane_keep_low: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `CMG_CTRL_OFFSET && !avs_byteenable[0])
    |=> (ctrl_reg[7:0] == $past(ctrl_reg[7:0])))
    else $error("disabled lower lane written");
  chk_ctrl_stable: assert property (@(posedge clk) disable iff (srst)
    avs_waitrequest |=> $stable(ctrl_reg)) else $error("control changed outside an answer");
  chk_state_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot(st_reg)) else $error("bus state not one-hot");
endmodule

// file: verification/cmg_src_model.sv
// Purpose: Stands in for the comparator and the three mask signal sources.
// Assumes: The bench picks one pattern of levels at a time.
// Notes: Pattern bits are mask A, mask B, mask C, comparator.
`timescale 1ns/1ps
module cmg_src_model (
  input wire logic [3:0] pattern,
  output logic mask_a,
  output logic mask_b,
  output logic mask_c,
  output logic comp_level
);
  assign {comp_level, mask_c, mask_b, mask_a} = pattern;
endmodule

// file: verification/testbench.sv
// Purpose: Self-checking bench of the comparator mask gating block.
// Assumes: Avalon-MM slave answers under its own waitrequest.
// Notes: Gating outputs are sampled on the falling edge.
`timescale 1ns/1ps
module testbench;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, comp_out, and_gate_result;
  logic mask_input_a, mask_input_b, mask_input_c, comp_in;
  logic [3:0] avs_address, avs_byteenable, pattern;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] ctl;
  int num_errors, compares, cycles;
  cmg_top dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mask_input_a(mask_input_a),
    .mask_input_b(mask_input_b), .mask_input_c(mask_input_c), .comp_in(comp_in),
    .comp_out(comp_out), .and_gate_result(and_gate_result));
  cmg_src_model src_u (.pattern(pattern), .mask_a(mask_input_a), .mask_b(mask_input_b),
    .mask_c(mask_input_c), .comp_level(comp_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Expected AND result and gated output for one control word and input pattern.
  function automatic logic [1:0] expect_gate(input logic [15:0] c, input logic [3:0] p);
    logic a, r;
    a = (|c[5:0]) && (!c[5] || p[2]) && (!c[4] || !p[2]) && (!c[3] || p[1]) && (!c[2] || !p[1])
      && (!c[1] || p[0]) && (!c[0] || !p[0]);
    r = (c[13] & p[2]) | (c[12] & !p[2]) | (c[11] & p[1]) | (c[10] & !p[1]) | (c[9] & p[0])
      | (c[8] & !p[0]) | (c[7] & !a) | (c[6] & a);
    return {a, r ? c[15] : p[3]};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_register();
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h0000FFFF, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h0000BFFF);
    bus(1'b1, 4'h0, 32'h00000000, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h0000BF00);
    bus(1'b1, 4'h0, 32'h000012FF, 4'h2);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h00001200);
    bus(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    check(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h00008200, 4'hF);
    @(posedge clk);
    pattern <= 4'h1;
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    check(rd, 32'h00000006);
  endtask
  localparam logic [15:0] extra_ctl [0:8] = '{16'h002A, 16'h0082, 16'h0006, 16'h0003, 16'h0300, 16'h3000,
    16'h0030, 16'h0C00, 16'h000C};
  task automatic test_gating();
    for (int i = 0; i < 23; i++) begin
      for (int j = 0; j < 4; j++) begin
        ctl = (i < 14) ? (16'h0001 << i) : extra_ctl[i - 14];
        ctl = ctl | (j[0] ? 16'h8000 : 16'h0000) | (j[1] ? 16'h0040 : 16'h0000);
        bus(1'b1, 4'h0, {16'h0000, ctl}, 4'hF);
        for (int p = 0; p < 16; p++) begin
          @(posedge clk);
          pattern <= p[3:0];
          @(negedge clk);
          check({30'h0, and_gate_result, comp_out}, {30'h0, expect_gate(ctl, p[3:0])});
        end
      end
    end
  endtask
  initial begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pattern = 4'h0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    test_register();
    test_gating();
    results();
  end
endmodule
